// *** hw/swr_pkg.sv ***
// Function
// RULE1: Sampling outranks function-layer bus traffic.
// RULE2: Interference forces all-ones bytes until reset.
// RULE3: Master waits 20 ms, resets, retries; the code returns to idle after that reset and does not retry the operation.
// RULE4: Depleted battery: backups ones, idle, count zero.
// RULE5: Read memory still reachable when battery depleted.
// RULE6: Device drives line only by open-drain pulldown.
// RULE7: Master idles high; overdrive lows stay short.
// RULE8: Reset, ROM command, function command, data.
// RULE9: Master reset pulse answered by presence pulse.
// RULE10: Eight ROM commands, each eight bits.
// RULE11: 33h sends family, serial, CRC identity.
// RULE12: 55h compares 64 bits; mismatch idles.
// RULE13: Search: true bit, complement, master bit.
// RULE14: Search mismatch drops out until reset.
// RULE15: ECh searches only with an alarm flag.
// RULE16: Temperature alarm needs enable; brownout always counts.
// RULE17: Completed conditional search selects like match.
// RULE18: CCh goes straight to function commands.
// RULE19: A5h proceeds only with resume flag set.
// RULE20: Resume flag set by selection, cleared otherwise; the code clears it only on a match or search mismatch.
// RULE21: 3Ch sets overdrive; long reset clears it.
// RULE22: 69h overdrive match; overdrive kept by others.
// RULE23: After overdrive skip, fast reset then select.
// RULE24: Unknown ROM code: ignore bus until reset.
package swr_pkg;
  localparam int unsigned CLK_NS = 4;
  localparam int          CW     = 23;
  typedef logic [CW-1:0] swr_cnt_t;

  function automatic int unsigned cyc_ceil(input int unsigned ns);
    cyc_ceil = (ns + CLK_NS - 1) / CLK_NS;
    if (cyc_ceil == 0) cyc_ceil = 1;
  endfunction

  function automatic int unsigned cyc_floor(input int unsigned ns);
    cyc_floor = (ns / CLK_NS == 0) ? 1 : ns / CLK_NS;
  endfunction

  // Device side times
  localparam int unsigned T_DRST_STD_NS  = 480000;
  localparam int unsigned T_DRST_OD_NS   = 48000;
  localparam int unsigned T_ODX_US       = 640;
  localparam int unsigned T_DPDH_STD_NS  = 15000;
  localparam int unsigned T_DPDH_OD_NS   = 2000;
  localparam int unsigned T_DPDL_STD_NS  = 90000;
  localparam int unsigned T_DPDL_OD_NS   = 10000;
  localparam int unsigned T_DSMP_STD_NS  = 15000;
  localparam int unsigned T_DSMP_OD_NS   = 2000;
  localparam int unsigned T_DRD0_STD_NS  = 15000;
  localparam int unsigned T_DRD0_OD_NS   = 3000;
  localparam swr_cnt_t DPDH_STD = swr_cnt_t'(cyc_ceil(T_DPDH_STD_NS));
  localparam swr_cnt_t DPDH_OD  = swr_cnt_t'(cyc_ceil(T_DPDH_OD_NS));
  localparam swr_cnt_t DPDL_OD  = swr_cnt_t'(cyc_ceil(T_DPDL_OD_NS));
  localparam swr_cnt_t DSMP_STD = swr_cnt_t'(cyc_ceil(T_DSMP_STD_NS));
  localparam swr_cnt_t DSMP_OD  = swr_cnt_t'(cyc_ceil(T_DSMP_OD_NS));
  localparam swr_cnt_t DRD0_STD = swr_cnt_t'(cyc_floor(T_DRD0_STD_NS));
  localparam swr_cnt_t DRD0_OD  = swr_cnt_t'(cyc_floor(T_DRD0_OD_NS));

  // Master side times
  localparam int unsigned T_HRST_STD_NS  = 680000;
  localparam int unsigned T_HRST_OD_NS   = 70000;
  localparam int unsigned T_HREC_STD_NS  = 480000;
  localparam int unsigned T_HREC_OD_NS   = 48000;
  localparam int unsigned T_HPS_STD_NS   = 70000;
  localparam int unsigned T_HPS_OD_NS    = 8000;
  localparam int unsigned T_HW1_STD_NS   = 6000;
  localparam int unsigned T_HW1_OD_NS    = 1000;
  localparam int unsigned T_HW0_STD_NS   = 60000;
  localparam int unsigned T_ODLOW_MAX_US = 12;
  localparam int unsigned T_HMS_STD_NS   = 12000;
  localparam int unsigned T_HMS_OD_NS    = 2000;
  localparam int unsigned T_HSLOT_STD_NS = 70000;
  localparam int unsigned T_HSLOT_OD_NS  = 16000;
  localparam int unsigned T_IFW_MS       = 20;
  localparam swr_cnt_t HW1_STD  = swr_cnt_t'(cyc_floor(T_HW1_STD_NS));
  localparam swr_cnt_t HW1_OD   = swr_cnt_t'(cyc_floor(T_HW1_OD_NS));
  localparam swr_cnt_t HW0_OD   = swr_cnt_t'(cyc_floor(T_ODLOW_MAX_US * 1000));
  localparam swr_cnt_t HMS_STD  = swr_cnt_t'(cyc_floor(T_HMS_STD_NS));
  localparam swr_cnt_t HMS_OD   = swr_cnt_t'(cyc_floor(T_HMS_OD_NS));
  localparam swr_cnt_t HPS_OD   = swr_cnt_t'(cyc_floor(T_HPS_OD_NS));
  localparam swr_cnt_t HSLOT_OD = swr_cnt_t'(cyc_ceil(T_HSLOT_OD_NS));

  // ROM function codes
  localparam logic [7:0] CMD_READ_ID  = 8'h33;
  localparam logic [7:0] CMD_MATCH    = 8'h55;
  localparam logic [7:0] CMD_SEARCH   = 8'hf0;
  localparam logic [7:0] CMD_CSEARCH  = 8'hec;
  localparam logic [7:0] CMD_SKIP     = 8'hcc;
  localparam logic [7:0] CMD_RESUME   = 8'ha5;
  localparam logic [7:0] CMD_OD_SKIP  = 8'h3c;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;

  // alarm_flags register and its fields
  localparam logic [15:0] ALARM_FLAGS_ADDR = 16'h0214;
  localparam int ALM_TLO = 0;
  localparam int ALM_THI = 1;
  localparam int ALM_BOR = 2;

  // Master command registers
  localparam int RA_W = 4;
  localparam logic [RA_W-1:0] R_CTRL = 4'h0;
  localparam logic [RA_W-1:0] R_TX   = 4'h4;
  localparam logic [RA_W-1:0] R_STAT = 4'h8;
  localparam logic [RA_W-1:0] R_RX   = 4'hc;
  localparam int CTRL_OD = 4;
  localparam logic [2:0] OP_RST   = 3'h1;
  localparam logic [2:0] OP_BYTE  = 3'h2;
  localparam logic [2:0] OP_TRIP  = 3'h3;
  localparam logic [2:0] OP_RECOV = 3'h4;
endpackage

// *** hw/swr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface swr_link_if;
  logic dev_oe;
  logic dev_out;
  logic host_oe;
  logic host_out;
  logic line;
  // Wired-AND with pullup
  assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));
  modport dev (input line, output dev_oe, output dev_out);
  modport host (input line, output host_oe, output host_out);
endinterface
`default_nettype wire

// *** hw/swr_slot.sv ***
`timescale 1ns/1ps
`default_nettype none
module swr_slot import swr_pkg::*; #(
  parameter int unsigned TIME_DIV = 1,
  parameter int unsigned RST_STD = 1,
  parameter int unsigned RST_OD  = 1,
  parameter int unsigned ODX     = 1,
  parameter int unsigned PDL_STD = 1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic line,
  input  wire logic od,
  input  wire logic tx_en,
  input  wire logic tx_bit,
  output logic      drv,
  output logic      rst_p,
  output logic      odx_p,
  output logic      bit_p,
  output logic      rx_bit
);
  import swr_pkg::*;
  typedef enum logic [1:0] {SL_IDLE, SL_LOW, SL_PDH, SL_PDL} swr_sl_t;
  swr_sl_t  st_q;
  swr_cnt_t cnt_q;
  swr_cnt_t rst_lim;
  swr_cnt_t smp;
  logic     rise;

  // Package times scaled down by a common divider
  function automatic swr_cnt_t sc(input swr_cnt_t v);
    sc = swr_cnt_t'(v / TIME_DIV);
  endfunction

  assign rst_lim = od ? swr_cnt_t'(RST_OD) : swr_cnt_t'(RST_STD);
  assign smp     = od ? sc(DSMP_OD) : sc(DSMP_STD);
  assign rise    = (st_q == SL_LOW) & line;
  assign rst_p   = rise & (cnt_q >= rst_lim);
  assign odx_p   = rise & (cnt_q >= swr_cnt_t'(ODX));
  assign bit_p   = rise & (cnt_q < rst_lim);
  // Open-drain only: presence pulse and read-zero pulldown [RULE6] [RULE9]
  assign drv = (st_q == SL_PDL) | ((st_q == SL_LOW) & tx_en & ~tx_bit &
               (cnt_q < (od ? sc(DRD0_OD) : sc(DRD0_STD))));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= SL_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        SL_IDLE: begin
          cnt_q <= '0;
          if (!line) st_q <= SL_LOW;
        end
        SL_LOW: begin
          if (line) begin
            st_q  <= (cnt_q >= rst_lim) ? SL_PDH : SL_IDLE;
            cnt_q <= '0;
          end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        SL_PDH: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= (od ? sc(DPDH_OD) : sc(DPDH_STD))) begin
            st_q  <= SL_PDL;
            cnt_q <= '0;
          end
        end
        SL_PDL: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= (od ? sc(DPDL_OD) : swr_cnt_t'(PDL_STD)))
            st_q <= SL_IDLE;
        end
        default: st_q <= SL_IDLE;
      endcase
    end
  end

  // Early release reads as a one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rx_bit <= 1'b1;
    else if (st_q == SL_IDLE && !line) rx_bit <= 1'b1;
    else if (st_q == SL_LOW && cnt_q == smp) rx_bit <= line;
  end
endmodule
`default_nettype wire

// *** hw/swr_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module swr_dev import swr_pkg::*; #(
  parameter int unsigned TIME_DIV    = 1,
  parameter int unsigned RST_STD_CYC = swr_pkg::cyc_ceil(
                                         swr_pkg::T_DRST_STD_NS) / TIME_DIV,
  parameter int unsigned RST_OD_CYC  = swr_pkg::cyc_ceil(
                                         swr_pkg::T_DRST_OD_NS) / TIME_DIV,
  parameter int unsigned ODX_CYC     = swr_pkg::cyc_ceil(
                                         swr_pkg::T_ODX_US * 1000) / TIME_DIV,
  parameter int unsigned PDL_STD_CYC = swr_pkg::cyc_ceil(
                                         swr_pkg::T_DPDL_STD_NS) / TIME_DIV
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  swr_link_if.dev          link,
  input  wire logic [63:0] dev_id,
  input  wire logic [7:0]  alarm_flags,
  input  wire logic [1:0]  temp_alarm_en,
  input  wire logic        sample_busy,
  input  wire logic        mission_active_flag,
  input  wire logic        wait_alarm_start,
  input  wire logic        extended_power_command,
  input  wire logic [31:0] backup_clock,
  input  wire logic [31:0] backup_stamp,
  input  wire logic [23:0] mission_count,
  input  wire logic        func_tx_en,
  input  wire logic        func_tx_bit,
  output logic             func_sel,
  output logic             func_rx_valid,
  output logic             func_rx_bit,
  output logic             resume_flag,
  output logic             overdrive_flag,
  output logic             interfere,
  output logic             batt_depleted
);
  import swr_pkg::*;
  typedef enum logic [2:0] {
    DV_IDLE, DV_CMD, DV_TXID, DV_RXID, DV_SRCH, DV_FUNC, DV_DEAD
  } swr_dv_t;

  swr_dv_t    st_q;
  logic [5:0] bitn_q;
  logic [1:0] ph_q;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic       rc_q;
  logic       od_q;
  logic       od_pre_q;
  logic       intf_q;
  logic       batt_q;
  logic       tx_en;
  logic       tx_bit;
  logic       drv;
  logic       rst_p;
  logic       odx_p;
  logic       bit_p;
  logic       rx_bit;
  logic       samp;
  logic       alarm_hit;
  logic       id_slot;
  logic       id_hit;
  logic       drop;
  logic       sel_ok;
  logic       cmd_end;

  swr_slot #(
    .TIME_DIV (TIME_DIV),
    .RST_STD (RST_STD_CYC),
    .RST_OD  (RST_OD_CYC),
    .ODX     (ODX_CYC),
    .PDL_STD (PDL_STD_CYC)
  ) u_slot (
    .clk     (clk),
    .sys_rst (sys_rst),
    .line    (link.line),
    .od      (od_q),
    .tx_en   (tx_en),
    .tx_bit  (tx_bit),
    .drv     (drv),
    .rst_p   (rst_p),
    .odx_p   (odx_p),
    .bit_p   (bit_p),
    .rx_bit  (rx_bit)
  );

  assign link.dev_oe  = drv;
  assign link.dev_out = 1'b0; // [RULE6]

  // ROM code decode after the eighth command bit
  function automatic swr_dv_t rom_next(input logic [7:0] c,
                                       input logic alm,
                                       input logic rc);
    case (c)
      CMD_READ_ID:  rom_next = DV_TXID; // [RULE11]
      CMD_MATCH:    rom_next = DV_RXID; // [RULE12]
      CMD_OD_MATCH: rom_next = DV_RXID; // [RULE22]
      CMD_SEARCH:   rom_next = DV_SRCH; // [RULE13]
      CMD_CSEARCH:  rom_next = alm ? DV_SRCH : DV_DEAD; // [RULE15]
      CMD_SKIP:     rom_next = DV_FUNC; // [RULE18]
      CMD_RESUME:   rom_next = rc ? DV_FUNC : DV_DEAD; // [RULE19]
      CMD_OD_SKIP:  rom_next = DV_FUNC; // [RULE21]
      default:      rom_next = DV_DEAD; // [RULE24]
    endcase
  endfunction

  // Temperature flags count only when enabled, brownout always
  assign alarm_hit = |(alarm_flags[ALM_THI:ALM_TLO] & temp_alarm_en) |
                     alarm_flags[ALM_BOR]; // [RULE16]

  // Periodic sampling during a mission or an alarm-start wait
  assign samp = sample_busy & (mission_active_flag | wait_alarm_start);

  assign cmd_d   = {rx_bit, cmd_q[7:1]};
  assign cmd_end = bit_p & (st_q == DV_CMD) & (bitn_q == 6'd7);
  assign id_slot = bit_p & ((st_q == DV_RXID) |
                   ((st_q == DV_SRCH) & (ph_q == 2'd2)));
  assign id_hit  = (rx_bit == dev_id[bitn_q]);
  assign drop    = id_slot & ~id_hit; // [RULE12] [RULE14]
  assign sel_ok  = id_slot & id_hit & (bitn_q == 6'd63);

  always_comb begin
    tx_en  = 1'b0;
    tx_bit = 1'b1;
    case (st_q)
      DV_TXID: begin
        tx_en  = 1'b1;
        tx_bit = dev_id[bitn_q]; // [RULE11]
      end
      DV_SRCH: begin
        tx_en  = (ph_q != 2'd2);
        tx_bit = dev_id[bitn_q] ^ ph_q[0]; // [RULE13]
      end
      DV_FUNC: begin
        // Sampling wins; interference reads back as ones [RULE1] [RULE2]
        tx_en  = func_tx_en & ~samp;
        tx_bit = func_tx_bit | intf_q;
      end
      default: begin
        tx_en  = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= DV_IDLE;
      bitn_q <= '0;
      ph_q   <= '0;
      cmd_q  <= '0;
    end else if (rst_p) begin
      st_q   <= DV_CMD; // [RULE8] [RULE9]
      bitn_q <= '0;
      ph_q   <= '0;
    end else if (bit_p) begin
      case (st_q)
        DV_CMD: begin
          cmd_q  <= cmd_d; // [RULE10]
          bitn_q <= bitn_q + 6'd1;
          if (bitn_q == 6'd7) begin
            bitn_q <= '0;
            st_q   <= rom_next(cmd_d, alarm_hit, rc_q);
          end
        end
        DV_TXID: begin
          bitn_q <= bitn_q + 6'd1;
          if (bitn_q == 6'd63) st_q <= DV_FUNC;
        end
        DV_RXID: begin
          bitn_q <= bitn_q + 6'd1;
          if (!id_hit) st_q <= DV_DEAD; // [RULE12]
          else if (bitn_q == 6'd63) st_q <= DV_FUNC;
        end
        DV_SRCH: begin
          if (ph_q != 2'd2) begin
            ph_q <= ph_q + 2'd1;
          end else begin
            ph_q   <= '0;
            bitn_q <= bitn_q + 6'd1;
            if (!id_hit) st_q <= DV_DEAD; // [RULE14]
            else if (bitn_q == 6'd63) st_q <= DV_FUNC; // [RULE17]
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // Resume flag: only a selection sets it, losing one clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rc_q <= 1'b0;
    else if (sel_ok) rc_q <= 1'b1; // [RULE20]
    else if (drop) rc_q <= 1'b0; // [RULE20]
  end

  // Overdrive flag; a failed fast match restores the previous speed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      od_q     <= 1'b0;
      od_pre_q <= 1'b0;
    end else if (odx_p) begin
      od_q <= 1'b0; // [RULE21]
    end else if (cmd_end && (cmd_d == CMD_OD_SKIP ||
                             cmd_d == CMD_OD_MATCH)) begin
      od_pre_q <= od_q;
      od_q     <= 1'b1; // [RULE21] [RULE22]
    end else if (drop && st_q == DV_RXID && cmd_q == CMD_OD_MATCH) begin
      od_q <= od_pre_q; // [RULE22]
    end
  end

  // Sticky until the next reset; a collision in the reset cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) intf_q <= 1'b0;
    else if (st_q == DV_FUNC && extended_power_command && samp)
      intf_q <= 1'b1; // [RULE2]
    else if (rst_p) intf_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) batt_q <= 1'b0;
    else batt_q <= (&backup_clock) & (&backup_stamp) &
                   ~mission_active_flag & (mission_count == 24'h000000);
  end // [RULE4]

  // Function hand-off is never blocked by the battery state [RULE5]
  assign func_sel       = (st_q == DV_FUNC);
  assign func_rx_valid  = bit_p & (st_q == DV_FUNC) & ~samp; // [RULE1]
  assign func_rx_bit    = rx_bit;
  assign resume_flag    = rc_q;
  assign overdrive_flag = od_q;
  assign interfere      = intf_q;
  assign batt_depleted  = batt_q;
endmodule
`default_nettype wire

// *** hw/swr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module swr_host import swr_pkg::*; #(
  parameter int unsigned TIME_DIV      = 1,
  parameter int unsigned HRST_STD_CYC  = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HRST_STD_NS) / TIME_DIV,
  parameter int unsigned HRST_OD_CYC   = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HRST_OD_NS) / TIME_DIV,
  parameter int unsigned HREC_STD_CYC  = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HREC_STD_NS) / TIME_DIV,
  parameter int unsigned HREC_OD_CYC   = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HREC_OD_NS) / TIME_DIV,
  parameter int unsigned HPS_STD_CYC   = swr_pkg::cyc_floor(
                                           swr_pkg::T_HPS_STD_NS) / TIME_DIV,
  parameter int unsigned HW0_STD_CYC   = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HW0_STD_NS) / TIME_DIV,
  parameter int unsigned HSLOT_STD_CYC = swr_pkg::cyc_ceil(
                                           swr_pkg::T_HSLOT_STD_NS) /
                                         TIME_DIV,
  parameter int unsigned IFW_CYC       = swr_pkg::cyc_ceil(
                                           swr_pkg::T_IFW_MS * 1000000) /
                                         TIME_DIV
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  swr_link_if.host                     link,
  input  wire logic [swr_pkg::RA_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata
);
  import swr_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_RST, H_REC, H_SLOT, H_WAIT} swr_hs_t;

  swr_hs_t    st_q;
  swr_cnt_t   cnt_q;
  logic [2:0] op_q;
  logic [2:0] bitn_q;
  logic [1:0] ph_q;
  logic [1:0] trip_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic       od_q;
  logic       pres_q;
  logic       go;
  logic       cur_bit;
  logic       smp_now;
  swr_cnt_t   low_lim;

  // Package times scaled down by a common divider
  function automatic swr_cnt_t sc(input swr_cnt_t v);
    sc = swr_cnt_t'(v / TIME_DIV);
  endfunction

  assign go = wr & (addr == R_CTRL) & (st_q == H_IDLE);

  always_comb begin
    cur_bit = tx_q[bitn_q];
    if (op_q == OP_TRIP) // [RULE13]
      cur_bit = (ph_q != 2'd2) |
                ((trip_q[0] ^ trip_q[1]) ? trip_q[0] : tx_q[0]);
  end

  assign low_lim = cur_bit ? (od_q ? sc(HW1_OD) : sc(HW1_STD))
                           : (od_q ? sc(HW0_OD) : swr_cnt_t'(HW0_STD_CYC));
  // Idle leaves the line high; fast-mode slot lows end by 12 us [RULE7]
  assign link.host_oe  = (st_q == H_RST) |
                         ((st_q == H_SLOT) & (cnt_q < low_lim));
  assign link.host_out = 1'b0;
  assign smp_now = (st_q == H_SLOT) &
                   (cnt_q == (od_q ? sc(HMS_OD) : sc(HMS_STD)));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= H_IDLE;
      cnt_q  <= '0;
      bitn_q <= '0;
      ph_q   <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      case (st_q)
        H_IDLE: begin
          cnt_q  <= '0;
          bitn_q <= '0;
          ph_q   <= '0;
          if (go) begin
            case (wdata[2:0])
              OP_RST:   st_q <= H_RST;
              OP_BYTE:  if (pres_q) st_q <= H_SLOT; // [RULE8]
              OP_TRIP:  if (pres_q) st_q <= H_SLOT; // [RULE8]
              OP_RECOV: st_q <= H_WAIT; // [RULE3]
              default:  st_q <= H_IDLE;
            endcase
          end
        end
        H_RST: begin
          // Speed of the reset follows the speed flag [RULE23]
          if (cnt_q >= (od_q ? swr_cnt_t'(HRST_OD_CYC)
                             : swr_cnt_t'(HRST_STD_CYC))) begin
            st_q  <= H_REC;
            cnt_q <= '0;
          end
        end
        H_REC: begin
          if (cnt_q >= (od_q ? swr_cnt_t'(HREC_OD_CYC)
                             : swr_cnt_t'(HREC_STD_CYC))) st_q <= H_IDLE;
        end
        H_SLOT: begin
          if (cnt_q >= (od_q ? sc(HSLOT_OD) : swr_cnt_t'(HSLOT_STD_CYC))) begin
            cnt_q <= '0;
            if (op_q == OP_TRIP) begin
              ph_q <= ph_q + 2'd1;
              if (ph_q == 2'd2) st_q <= H_IDLE;
            end else begin
              bitn_q <= bitn_q + 3'd1;
              if (bitn_q == 3'd7) st_q <= H_IDLE;
            end
          end
        end
        H_WAIT: begin
          if (cnt_q >= swr_cnt_t'(IFW_CYC)) begin
            st_q  <= H_RST; // [RULE3]
            cnt_q <= '0;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_q <= '0;
      od_q <= 1'b0;
      tx_q <= 8'hff;
    end else begin
      if (go) begin
        op_q <= wdata[2:0];
        od_q <= wdata[CTRL_OD];
      end
      if (wr && addr == R_TX && st_q == H_IDLE) tx_q <= wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pres_q <= 1'b0;
      rx_q   <= 8'hff;
      trip_q <= 2'b00;
    end else begin
      if (st_q == H_REC && cnt_q == (od_q ? sc(HPS_OD)
                                          : swr_cnt_t'(HPS_STD_CYC)))
        pres_q <= ~link.line; // [RULE9]
      if (smp_now && op_q == OP_BYTE) rx_q[bitn_q] <= link.line;
      if (smp_now && op_q == OP_TRIP) begin
        if (ph_q == 2'd2) rx_q[0] <= link.line;
        else trip_q[ph_q[0]] <= link.line;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdata <= '0;
    else if (!rd) rdata <= '0;
    else begin
      case (addr)
        R_CTRL:  rdata <= {27'h0, od_q, 1'b0, op_q};
        R_TX:    rdata <= {24'h0, tx_q};
        R_STAT:  rdata <= {27'h0, trip_q, od_q, pres_q, st_q != H_IDLE};
        R_RX:    rdata <= {24'h0, rx_q};
        default: rdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/swr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module swr_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic host_oe,
  input wire logic host_out,
  input wire logic line
);
  logic [15:0] hlo_q;
  // Length of the current master low pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) hlo_q <= '0;
    else hlo_q <= host_oe ? hlo_q + 16'h1 : 16'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rst;
    $fell(host_oe) && hlo_q >= 16'd400;
  endsequence
  a_dev_open_drain: assert property (dev_oe |-> !dev_out)
    else $error("device drives high");
  a_dev_pulls_low: assert property (dev_oe |-> !line)
    else $error("line high under device pulldown");
  a_host_open_drain: assert property (host_oe |-> !host_out)
    else $error("master drives high");
  a_idle_line_high: assert property (!dev_oe && !host_oe |-> line)
    else $error("released line not high");
  a_quiet_in_reset: assert property (hlo_q >= 16'd400 |-> !dev_oe)
    else $error("device drives during reset pulse");
  a_presence_wait: assert property (s_rst |-> (!dev_oe) [*8])
    else $error("presence too early");
  a_presence_seen: assert property (s_rst |-> ##[1:200] dev_oe)
    else $error("no presence after reset");
  a_dev_releases: assert property (dev_oe |-> ##[1:200] !dev_oe)
    else $error("device holds line");
endmodule
`default_nettype wire

// *** sim/test_single_wire_rom_layer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_rom_layer;
  import swr_pkg::*;
  localparam int unsigned TDIV = 250;
  logic        clk = 0, sys_rst = 1, wr = 0, rd = 0, mact = 0;
  logic        sb = 0, was = 0, epc = 0, fte = 0, ftb = 0;
  logic [1:0]  tae = '0;
  logic [3:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, d, bclk = '0, bstp = '0;
  logic [63:0] id = '0;
  logic [7:0]  alm = '0;
  logic [23:0] cnt = '0;
  logic        fs, rc, od, bd, intf;
  int          errors = 0, n_compared = 0, cyc = 0, k;
  swr_link_if link ();
  always #2 clk = ~clk;
  swr_dev #(.TIME_DIV(TDIV)) swr_dev_inst (.clk(clk), .sys_rst(sys_rst),
    .link(link), .dev_id(id), .alarm_flags(alm), .temp_alarm_en(tae),
    .sample_busy(sb), .mission_active_flag(mact),
    .wait_alarm_start(was), .extended_power_command(epc),
    .backup_clock(bclk), .backup_stamp(bstp), .mission_count(cnt),
    .func_tx_en(fte), .func_tx_bit(ftb), .func_sel(fs),
    .func_rx_valid(), .func_rx_bit(), .resume_flag(rc),
    .overdrive_flag(od), .interfere(intf), .batt_depleted(bd));
  swr_host #(.TIME_DIV(TDIV)) swr_host_inst (.clk(clk),
    .sys_rst(sys_rst), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  swr_monitor swr_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .dev_oe(link.dev_oe), .dev_out(link.dev_out), .host_oe(link.host_oe),
    .host_out(link.host_out), .line(link.line));
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 110000) begin
      errors = errors + 1;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic op(input logic [2:0] c, input logic o);
    wrr(R_CTRL, {27'h0, o, 1'b0, c});
    d = 32'h1;
    while (d[0] !== 1'b0) rdr(R_STAT);
  endtask
  task automatic xb(input logic [7:0] b, input logic o);
    wrr(R_TX, {24'h0, b});
    op(OP_BYTE, o);
    rdr(R_RX);
  endtask
  task automatic rom(input logic [7:0] c, input logic o);
    op(OP_RST, o);
    rdr(R_STAT);
    chk(d[1], 1'b1);
    xb(c, o);
  endtask
  task automatic ids(input logic [63:0] v, input logic o);
    for (int i = 0; i < 8; i++) xb(v[8*i+:8], o);
  endtask
  task automatic srch(input logic [7:0] c, input logic p);
    rom(c, 1'b0);
    for (int i = 0; i < 64; i++) begin
      wrr(R_TX, {31'h0, id[i]});
      op(OP_TRIP, 1'b0);
      rdr(R_STAT);
      chk(d[4:3], p ? {~id[i], id[i]} : 2'b11);
    end
    chk(fs, p);
    $display("search %h done", c);
  endtask
  initial begin
    void'($urandom(14067));
    id = {$urandom, $urandom};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rom(CMD_SKIP, 1'b0);
    chk(fs, 1'b1);
    rom(CMD_READ_ID, 1'b0);
    for (k = 0; k < 8; k++) begin
      xb(8'hff, 1'b0);
      chk(d[7:0], id[8*k+:8]);
    end
    rom(CMD_MATCH, 1'b0);
    ids(id, 1'b0);
    chk({fs, rc}, 2'b11);
    rom(CMD_RESUME, 1'b0);
    chk(fs, 1'b1);
    rom(CMD_MATCH, 1'b0);
    ids(id ^ 64'h1, 1'b0);
    chk({fs, rc}, 2'b00);
    rom(CMD_RESUME, 1'b0);
    chk(fs, 1'b0);
    $display("select tests done");
    srch(CMD_SEARCH, 1'b1);
    chk(rc, 1'b1);
    srch(CMD_CSEARCH, 1'b0);
    alm <= 8'h02;
    srch(CMD_CSEARCH, 1'b0);
    alm <= 8'h04;
    srch(CMD_CSEARCH, 1'b1);
    rom(8'h0f, 1'b0);
    chk(fs, 1'b0);
    rom(CMD_OD_SKIP, 1'b0);
    chk({od, fs}, 2'b11);
    rom(CMD_SKIP, 1'b0);
    chk(od, 1'b0);
    rom(CMD_OD_MATCH, 1'b0);
    ids(id, 1'b1);
    chk({od, fs}, 2'b11);
    $display("speed tests done");
    bclk <= '1;
    bstp <= '1;
    repeat (2) @(posedge clk);
    chk(bd, 1'b1);
    cnt <= 24'h1;
    repeat (2) @(posedge clk);
    chk(bd, 1'b0);
    $display("battery test done");
    sb <= 1'b1;
    mact <= 1'b1;
    epc <= 1'b1;
    repeat (2) @(posedge clk);
    chk(intf, 1'b1);
    $display("interference test done");
    finish_test();
  end
endmodule
`default_nettype wire
